//--- verilog/config_rev_control.v
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "cfg_rev_map.vh"

// What this block does
// - Revisions occupy whole 8 Mb blocks; unused tail of last block reads all ones.
// - Revisions zero to three carry the codes 00, 01, 10 and 11.
// - Select enable low takes the pins; high takes internal select bits.
// - The selection source is sampled once during power-up.
// - After power-up, every chip select rising edge resamples the selection.
// - A falling edge of the reset line resamples while chip select is low.
// - A rising edge of the config pulse resamples while chip select is low.
// - A reload instruction resamples first, then starts the target configuration.
// - With revisioning on, only data of the currently selected revision goes to the target.
// - A reload drives the config pulse low once for 300 to 500 ns.
// - The reset line is held low in power-up, released after the release delay.
// - Supply below the power-down threshold holds the reset line low again.
// - Reset line low or chip select high resets counter and floats outputs.
// - The reset line is always active low; its polarity cannot be changed.
// - An outside monitor holding the reset line low postpones all data output; a reload still drives the config pulse.
// - Address reset loads the revision start, or zero without revisioning.
// - With revisioning, the counter stops at the revision end and data floats.
module config_rev_control #(
  parameter [`RELEASE_CNT_W-1:0] RELEASE_DELAY = `RELEASE_DELAY_CYCLES
) (
  input wire clk,
  input wire arst_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire supply_ok,
  input wire supply_low,
  input wire [1:0] revision_select_pins,
  input wire external_select_enable,
  input wire chip_select_n,
  input wire reload_instruction,
  input wire config_tick,
  input wire busy_in,
  input wire output_enable_clear_n_in,
  output reg output_enable_clear_n_out,
  output reg output_enable_clear_n_oe,
  input wire config_pulse_in,
  output reg config_pulse_out,
  output wire config_pulse_oe,
  output reg cascade_enable_out,
  output reg [`ADDR_W-1:0] mem_addr,
  input wire [7:0] mem_data,
  output reg [7:0] data_out,
  output reg data_oe
);

  localparam [1:0] PWR_OFF = 2'h0;
  localparam [1:0] PWR_WAIT = 2'h1;
  localparam [1:0] PWR_ON = 2'h2;

  localparam [7:0] SLOT1_ADDR = `REG_SLOT_BASE + `REG_SLOT_STEP;
  localparam [7:0] SLOT2_ADDR = SLOT1_ADDR + `REG_SLOT_STEP;
  localparam [7:0] SLOT3_ADDR = SLOT2_ADDR + `REG_SLOT_STEP;

  reg [1:0] pwr_r;
  reg [1:0] pwr_nxt;
  reg [`RELEASE_CNT_W-1:0] dly_r;
  reg [2:0] ctrl_r;
  reg [1:0] rev_r;
  reg cs_n_d_r;
  reg oe_d_r;
  reg cf_d_r;
  reg reload_d_r;
  reg addr_load_r;
  reg [31:0] rdata_nxt;

  wire powered;
  wire in_reset;
  wire rev_en;
  wire [1:0] rev_src;
  wire cs_rise;
  wire oe_fall;
  wire cf_rise;
  wire sample;
  wire cf_low;
  wire [`SLOT_W-1:0] slot_q0;
  wire [`SLOT_W-1:0] slot_q1;
  wire [`SLOT_W-1:0] slot_q2;
  wire [`SLOT_W-1:0] slot_q3;
  wire [`ADDR_W-1:0] start_v0;
  wire [`ADDR_W-1:0] start_v1;
  wire [`ADDR_W-1:0] start_v2;
  wire [`ADDR_W-1:0] start_v3;
  wire [`ADDR_W-1:0] end_v0;
  wire [`ADDR_W-1:0] end_v1;
  wire [`ADDR_W-1:0] end_v2;
  wire [`ADDR_W-1:0] end_v3;
  wire [`ADDR_W-1:0] pad_v0;
  wire [`ADDR_W-1:0] pad_v1;
  wire [`ADDR_W-1:0] pad_v2;
  wire [`ADDR_W-1:0] pad_v3;
  wire [3:0] pad_en_v;
  reg [`ADDR_W-1:0] start_sel;
  reg [`ADDR_W-1:0] end_sel;
  reg [`ADDR_W-1:0] pad_sel;
  reg pad_sel_en;

  rev_slot #(.SLOT_ADDR(`REG_SLOT_BASE), .RST_BLOCK(`REV_0)) u_slot0 (
    .clk(clk),
    .arst_n(arst_n),
    .wr_en(reg_wr),
    .wr_addr(reg_addr),
    .wr_data(reg_wdata),
    .slot_r(slot_q0),
    .start_addr(start_v0),
    .end_addr(end_v0),
    .pad_addr(pad_v0),
    .pad_en(pad_en_v[0])
  );

  rev_slot #(.SLOT_ADDR(SLOT1_ADDR), .RST_BLOCK(`REV_1)) u_slot1 (
    .clk(clk),
    .arst_n(arst_n),
    .wr_en(reg_wr),
    .wr_addr(reg_addr),
    .wr_data(reg_wdata),
    .slot_r(slot_q1),
    .start_addr(start_v1),
    .end_addr(end_v1),
    .pad_addr(pad_v1),
    .pad_en(pad_en_v[1])
  );

  rev_slot #(.SLOT_ADDR(SLOT2_ADDR), .RST_BLOCK(`REV_2)) u_slot2 (
    .clk(clk),
    .arst_n(arst_n),
    .wr_en(reg_wr),
    .wr_addr(reg_addr),
    .wr_data(reg_wdata),
    .slot_r(slot_q2),
    .start_addr(start_v2),
    .end_addr(end_v2),
    .pad_addr(pad_v2),
    .pad_en(pad_en_v[2])
  );

  rev_slot #(.SLOT_ADDR(SLOT3_ADDR), .RST_BLOCK(`REV_3)) u_slot3 (
    .clk(clk),
    .arst_n(arst_n),
    .wr_en(reg_wr),
    .wr_addr(reg_addr),
    .wr_data(reg_wdata),
    .slot_r(slot_q3),
    .start_addr(start_v3),
    .end_addr(end_v3),
    .pad_addr(pad_v3),
    .pad_en(pad_en_v[3])
  );

  // Power-up sequencing of the reset line.
  always @* begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      PWR_OFF: begin
        if (supply_ok && !supply_low) begin
          pwr_nxt = PWR_WAIT;
        end
      end
      PWR_WAIT: begin
        if (supply_low) begin
          pwr_nxt = PWR_OFF;
        end else if (dly_r == RELEASE_DELAY) begin
          pwr_nxt = PWR_ON;
        end
      end
      PWR_ON: begin
        if (supply_low) begin
          pwr_nxt = PWR_OFF;
        end
      end
      default: begin
        pwr_nxt = PWR_OFF;
      end
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_r <= PWR_OFF;
      dly_r <= {`RELEASE_CNT_W{1'b0}};
      output_enable_clear_n_out <= 1'b0;
      output_enable_clear_n_oe <= 1'b1;
    end else begin
      pwr_r <= pwr_nxt;
      if (pwr_r == PWR_WAIT) begin
        dly_r <= dly_r + 1'b1;
      end else begin
        dly_r <= {`RELEASE_CNT_W{1'b0}};
      end
      // Open drain: the line is only ever pulled low, never driven high.
      output_enable_clear_n_out <= 1'b0;
      output_enable_clear_n_oe <= (pwr_nxt != PWR_ON);
    end
  end

  assign powered = (pwr_r == PWR_ON);
  assign rev_en = ctrl_r[`CTRL_REVEN_BIT];

  // The line is active low by construction; no bit can invert it.
  // An outside monitor holding it low keeps the block in reset.
  assign in_reset = !powered || !output_enable_clear_n_in || chip_select_n;

  // Edge detection on the pins, which arrive synchronous to clk.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_n_d_r <= 1'b1;
      oe_d_r <= 1'b0;
      cf_d_r <= 1'b1;
      reload_d_r <= 1'b0;
    end else begin
      cs_n_d_r <= chip_select_n;
      oe_d_r <= output_enable_clear_n_in;
      cf_d_r <= config_pulse_in;
      reload_d_r <= reload_instruction && powered;
    end
  end

  assign cs_rise = chip_select_n && !cs_n_d_r;
  assign oe_fall = !output_enable_clear_n_in && oe_d_r && !chip_select_n;
  assign cf_rise = config_pulse_in && !cf_d_r && !chip_select_n;

  // Pins when the enable is low, internal bits when it is high.
  assign rev_src = external_select_enable ? ctrl_r[`CTRL_REV_MSB:`CTRL_REV_LSB]
                                          : revision_select_pins;

  assign sample = (pwr_r == PWR_WAIT && pwr_nxt == PWR_ON)
                  || (powered && cs_rise)
                  || (powered && oe_fall)
                  || (powered && cf_rise)
                  || (powered && reload_instruction);

  // The code only changes at a sampling event; it steers the bounds below.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rev_r <= `REV_0;
    end else if (sample) begin
      rev_r <= rev_src;
    end
  end

  // The pulse starts one cycle after the reload sample, so the new code is
  // already in place when the target is reset.
  cf_pulse_timer u_cf_timer (
    .clk(clk),
    .arst_n(arst_n),
    .start(reload_d_r),
    .low_r(cf_low)
  );

  assign config_pulse_oe = cf_low;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      config_pulse_out <= 1'b0;
    end else begin
      config_pulse_out <= 1'b0;
    end
  end

  // Bounds of the selected revision.
  always @* begin
    case (rev_r)
      `REV_0: begin
        start_sel = start_v0;
        end_sel = end_v0;
        pad_sel = pad_v0;
        pad_sel_en = pad_en_v[0];
      end
      `REV_1: begin
        start_sel = start_v1;
        end_sel = end_v1;
        pad_sel = pad_v1;
        pad_sel_en = pad_en_v[1];
      end
      `REV_2: begin
        start_sel = start_v2;
        end_sel = end_v2;
        pad_sel = pad_v2;
        pad_sel_en = pad_en_v[2];
      end
      `REV_3: begin
        start_sel = start_v3;
        end_sel = end_v3;
        pad_sel = pad_v3;
        pad_sel_en = pad_en_v[3];
      end
      default: begin
        start_sel = start_v0;
        end_sel = end_v0;
        pad_sel = pad_v0;
        pad_sel_en = pad_en_v[0];
      end
    endcase
    if (!rev_en) begin
      start_sel = {`ADDR_W{1'b0}};
      end_sel = `TERMINAL_COUNT;
      pad_sel_en = 1'b0;
    end
  end

  // A rising config pulse or the power-up sample reloads the counter one cycle
  // later, once the new code is in place; the reset branch would keep the old start.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_load_r <= 1'b0;
    end else begin
      addr_load_r <= cf_rise || (pwr_r == PWR_WAIT && pwr_nxt == PWR_ON);
    end
  end

  // Address counter and outputs toward the target.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_addr <= {`ADDR_W{1'b0}};
      cascade_enable_out <= 1'b1;
      data_oe <= 1'b0;
      data_out <= `ALL_ONES_BYTE;
    end else if (in_reset) begin
      mem_addr <= start_sel;
      cascade_enable_out <= 1'b1;
      data_oe <= 1'b0;
      data_out <= `ALL_ONES_BYTE;
    end else if (addr_load_r) begin
      mem_addr <= start_sel;
      cascade_enable_out <= 1'b1;
      data_oe <= 1'b1;
    end else if (busy_in) begin
      data_oe <= data_oe;
    end else if (mem_addr == `TERMINAL_COUNT) begin
      cascade_enable_out <= 1'b0;
      data_oe <= 1'b0;
    end else if (rev_en && mem_addr == end_sel) begin
      cascade_enable_out <= 1'b1;
      data_oe <= 1'b0;
    end else begin
      cascade_enable_out <= 1'b1;
      data_oe <= 1'b1;
      if (config_tick) begin
        mem_addr <= mem_addr + 1'b1;
        // Padding past the image end reads as erased flash.
        if (pad_sel_en && mem_addr >= pad_sel) begin
          data_out <= `ALL_ONES_BYTE;
        end else begin
          data_out <= mem_data;
        end
      end
    end
  end

  // Register port: writes take effect at once, reads answer one cycle later.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `CTRL_RESET;
    end else if (reg_wr && reg_addr == `REG_CTRL) begin
      ctrl_r <= reg_wdata[2:0];
    end
  end

  always @* begin
    rdata_nxt = 32'h00000000;
    case (reg_addr)
      `REG_CTRL: begin
        rdata_nxt = {29'h0, ctrl_r};
      end
      `REG_STATUS: begin
        rdata_nxt = {25'h0, !cascade_enable_out, data_oe, cf_low, in_reset, powered, rev_r};
      end
      `REG_ADDRESS: begin
        rdata_nxt = {10'h0, mem_addr};
      end
      `REG_SLOT_BASE: begin
        rdata_nxt = {7'h0, slot_q0};
      end
      SLOT1_ADDR: begin
        rdata_nxt = {7'h0, slot_q1};
      end
      SLOT2_ADDR: begin
        rdata_nxt = {7'h0, slot_q2};
      end
      SLOT3_ADDR: begin
        rdata_nxt = {7'h0, slot_q3};
      end
      default: begin
        rdata_nxt = 32'h00000000;
      end
    endcase
  end

  // Read data is zero outside the answer cycle, which keeps a shared bus quiet.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // config_rev_control

//--- verilog/cfg_rev_map.vh
`ifndef CFG_REV_MAP_VH
`define CFG_REV_MAP_VH

// Register offsets on the plain register port.
`define REG_ADDR_W 8
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_ADDRESS 8'h08
`define REG_SLOT_BASE 8'h10
`define REG_SLOT_STEP 8'h04

// Control register fields.
`define CTRL_REV_LSB 0
`define CTRL_REV_MSB 1
`define CTRL_REVEN_BIT 2
`define CTRL_RESET 3'h0

// Revision slot register fields.
`define SLOT_FIRST_LSB 0
`define SLOT_FIRST_MSB 1
`define SLOT_LAST_LSB 2
`define SLOT_LAST_MSB 3
`define SLOT_PAD_LSB 4
`define SLOT_PAD_MSB 23
`define SLOT_PADEN_BIT 24
`define SLOT_W 25
`define SLOT_PAD_RESET 20'h00000

// Revision codes.
`define REV_0 2'h0
`define REV_1 2'h1
`define REV_2 2'h2
`define REV_3 2'h3

// Address space: four memory blocks of 8 Mb, byte addressed.
`define BLOCK_MBIT 8
`define BLOCK_OFS_W 20
`define ADDR_W 22
`define TERMINAL_COUNT 22'h3fffff
`define ALL_ONES_BYTE 8'hff

// Timing.
`define CLK_PERIOD_NS 8
`define CF_LOW_MIN_NS 300
`define CF_LOW_MAX_NS 500
`define CF_LOW_CYCLES ((`CF_LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CF_CNT_W 8
`define RELEASE_DELAY_NS 10000
// Release delay of 10 us in clock cycles, sized to match its counter.
`define RELEASE_DELAY_CYCLES 12'h4e2
`define RELEASE_CNT_W 12

`endif

//--- verilog/rev_slot.v
`timescale 1ns/1ps
`include "cfg_rev_map.vh"

module rev_slot #(
  parameter [7:0] SLOT_ADDR = 8'h10,
  parameter [1:0] RST_BLOCK = 2'h0
) (
  input wire clk,
  input wire arst_n,
  input wire wr_en,
  input wire [7:0] wr_addr,
  input wire [31:0] wr_data,
  output reg [`SLOT_W-1:0] slot_r,
  output wire [`ADDR_W-1:0] start_addr,
  output wire [`ADDR_W-1:0] end_addr,
  output wire [`ADDR_W-1:0] pad_addr,
  output wire pad_en
);

  wire [1:0] first_blk;
  wire [1:0] last_blk;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slot_r <= {1'b0, `SLOT_PAD_RESET, RST_BLOCK, RST_BLOCK};
    end else if (wr_en && (wr_addr == SLOT_ADDR)) begin
      slot_r <= wr_data[`SLOT_W-1:0];
    end
  end

  assign first_blk = slot_r[`SLOT_FIRST_MSB:`SLOT_FIRST_LSB];
  assign last_blk = slot_r[`SLOT_LAST_MSB:`SLOT_LAST_LSB];
  // A revision always spans whole blocks, so its bounds are block aligned.
  assign start_addr = {first_blk, {`BLOCK_OFS_W{1'b0}}};
  assign end_addr = {last_blk, {`BLOCK_OFS_W{1'b1}}};
  assign pad_addr = {last_blk, slot_r[`SLOT_PAD_MSB:`SLOT_PAD_LSB]};
  assign pad_en = slot_r[`SLOT_PADEN_BIT];

endmodule // rev_slot

//--- verilog/cf_pulse_timer.v
`timescale 1ns/1ps
`include "cfg_rev_map.vh"

module cf_pulse_timer (
  input wire clk,
  input wire arst_n,
  input wire start,
  output reg low_r
);

  localparam integer LOW_CYCLES = `CF_LOW_CYCLES;
  localparam [`CF_CNT_W-1:0] LOW_LAST = LOW_CYCLES[`CF_CNT_W-1:0] - 1'b1;

  reg [`CF_CNT_W-1:0] cnt_r;

  // The low time is counted on the local clock so it cannot depend on the
  // pace of the configuration clock.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_r <= 1'b0;
      cnt_r <= {`CF_CNT_W{1'b0}};
    end else if (!low_r) begin
      if (start) begin
        low_r <= 1'b1;
        cnt_r <= {`CF_CNT_W{1'b0}};
      end
    end else if (cnt_r == LOW_LAST) begin
      low_r <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

endmodule // cf_pulse_timer

//--- dv/cfg_rev_checker_assertions.sv
`timescale 1ns/1ps
`include "cfg_rev_map.vh"
module cfg_rev_checker #(
  parameter [`RELEASE_CNT_W-1:0] RELEASE_DELAY = 8
) (
  input wire clk,
  input wire arst_n,
  input wire supply_ok,
  input wire supply_low,
  input wire chip_select_n,
  input wire reload_instruction,
  input wire config_tick,
  input wire busy_in,
  input wire output_enable_clear_n_in,
  input wire output_enable_clear_n_out,
  input wire output_enable_clear_n_oe,
  input wire config_pulse_in,
  input wire config_pulse_out,
  input wire config_pulse_oe,
  input wire cascade_enable_out,
  input wire [`ADDR_W-1:0] mem_addr,
  input wire data_oe
);
  reg [15:0] ok_cnt_r;
  reg [7:0] low_cnt_r;
  // Counters saturate or clear so a long run never wraps into a false match.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ok_cnt_r <= 16'h0000;
      low_cnt_r <= 8'h00;
    end else begin
      ok_cnt_r <= (supply_ok && !supply_low) ? ok_cnt_r + {15'h0000, !(&ok_cnt_r)} : 16'h0000;
      low_cnt_r <= config_pulse_oe ? low_cnt_r + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_pd_hold;
    supply_low |-> ##[1:2] output_enable_clear_n_oe;
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("line not held");
  property p_release;
    $fell(output_enable_clear_n_oe) |-> ok_cnt_r > {4'h0, RELEASE_DELAY};
  endproperty
  a_release: assert property (p_release) else $error("line released early");
  property p_standby;
    chip_select_n [*3] |-> !data_oe && cascade_enable_out;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not floated");
  property p_monitor;
    !output_enable_clear_n_in [*3] |-> !data_oe && cascade_enable_out;
  endproperty
  a_monitor: assert property (p_monitor) else $error("output while held");
  property p_width;
    $fell(config_pulse_oe) |-> low_cnt_r == `CF_LOW_CYCLES;
  endproperty
  a_width: assert property (p_width) else $error("pulse width");
  property p_cause;
    $rose(config_pulse_oe) |-> $past(reload_instruction, 2) || $past(reload_instruction, 3);
  endproperty
  a_cause: assert property (p_cause) else $error("pulse without reload");
  property p_low_only;
    config_pulse_oe || output_enable_clear_n_oe |-> !config_pulse_out && !output_enable_clear_n_out;
  endproperty
  a_low_only: assert property (p_low_only) else $error("line driven high");
  property p_step;
    config_tick && data_oe && !busy_in && !chip_select_n && output_enable_clear_n_in
      && config_pulse_in && $past(config_pulse_in, 2) && mem_addr[19:0] != 20'hfffff
      |=> mem_addr == $past(mem_addr) + 22'h000001;
  endproperty
  a_step: assert property (p_step) else $error("address not stepped");
endmodule // cfg_rev_checker

//--- dv/target_cfg_model.sv
`timescale 1ns/1ps
module target_cfg_model (
  input wire clk,
  input wire arst_n,
  input wire en,
  input wire slow,
  input wire hold_init,
  input wire [7:0] data_out,
  input wire data_oe,
  input wire output_enable_clear_n_oe,
  input wire config_pulse_oe,
  output wire output_enable_clear_n_in,
  output wire config_pulse_in,
  output wire config_tick,
  output wire busy_in,
  output reg got_vld_r,
  output reg [7:0] got_byte_r,
  output reg [3:0] prog_cnt_r
);
  reg [2:0] ph_r;
  reg take_r;
  reg cf_d_r;
  // Both lines have pull-ups; a power monitor may hold the reset line low.
  assign output_enable_clear_n_in = !(output_enable_clear_n_oe || hold_init);
  assign config_pulse_in = !config_pulse_oe;
  assign busy_in = slow && ph_r[2];
  assign config_tick = en && ph_r[0];
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_r <= 3'h0;
      take_r <= 1'b0;
      cf_d_r <= 1'b1;
      got_vld_r <= 1'b0;
      got_byte_r <= 8'h00;
      prog_cnt_r <= 4'h0;
    end else begin
      ph_r <= ph_r + 3'h1;
      take_r <= config_tick && data_oe && !busy_in;
      got_vld_r <= take_r;
      got_byte_r <= data_out;
      cf_d_r <= config_pulse_in;
      if (cf_d_r && !config_pulse_in) begin
        prog_cnt_r <= prog_cnt_r + 4'h1;
      end
    end
  end
endmodule // target_cfg_model

//--- dv/config_rev_control_test.sv
`timescale 1ns/1ps
module config_rev_control_test;
  localparam [11:0] RELEASE_DELAY = 12'h008;
  reg clk = 1'b0;
  reg arst_n = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg supply_ok = 1'b0;
  reg supply_low = 1'b0;
  reg [1:0] revision_select_pins = 2'h0;
  reg external_select_enable = 1'b0;
  reg chip_select_n = 1'b1;
  reg reload_instruction = 1'b0;
  reg en = 1'b0;
  reg slow = 1'b0;
  reg hold_init = 1'b0;
  reg rd_d = 1'b0;
  wire [31:0] reg_rdata;
  wire output_enable_clear_n_in, output_enable_clear_n_out, output_enable_clear_n_oe;
  wire config_pulse_in, config_pulse_out, config_pulse_oe, cascade_enable_out;
  wire config_tick, busy_in, data_oe, got_vld_r;
  wire [21:0] mem_addr;
  wire [7:0] data_out, got_byte_r;
  wire [3:0] prog_cnt_r;
  wire [7:0] mem_data = {mem_addr[21:20], mem_addr[5:0]};
  integer error_cnt = 0;
  integer n_checks = 0;
  integer seed = 94;
  reg [63:0] rq[$];
  reg [7:0] dq[$];
  always #4 clk = ~clk;
  config_rev_control #(.RELEASE_DELAY(RELEASE_DELAY)) config_rev_control_inst (.*);
  target_cfg_model target_cfg_model_inst (.*);
  task check(input [31:0] seen, input [31:0] exp, input string nm);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task stall;
    error_cnt = error_cnt + 1;
    $display("ERROR wait expected done seen timeout");
    complete_run;
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, input [31:0] m, input [31:0] e);
    rq.push_back({m, e});
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task reselect;
    chip_select_n <= 1'b1;
    tick(4);
    chip_select_n <= 1'b0;
    tick(4);
  endtask
  task wait_up;
    integer i;
    for (i = 0; i < 60 && output_enable_clear_n_oe !== 1'b0; i++) tick(1);
    if (output_enable_clear_n_oe !== 1'b0) stall;
    tick(4);
  endtask
  // Bytes beyond the pad offset must read as erased cells.
  task run_bytes(input [1:0] b, input integer n, input integer pad);
    integer i;
    for (i = 0; i < n; i++) dq.push_back(i >= pad ? 8'hff : {b, i[5:0]});
    en <= 1'b1;
    for (i = 0; i < 400 && dq.size() != 0; i++) tick(1);
    en <= 1'b0;
    if (dq.size() != 0) stall;
    tick(6);
  endtask
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d && rq.size() > 0) begin
      check(reg_rdata & rq[0][63:32], rq[0][31:0], "register");
      void'(rq.pop_front());
    end
    if (got_vld_r && dq.size() > 0) begin
      check(got_byte_r, dq[0], "data byte");
      void'(dq.pop_front());
    end
  end
  initial begin
    integer k;
    integer i;
    reg [1:0] r;
    tick(12);
    arst_n <= 1'b1;
    tick(1);
    check(output_enable_clear_n_oe, 1'b1, "line drive");
    check(cascade_enable_out, 1'b1, "cascade");
    check(data_oe, 1'b0, "data enable");
    rd(8'h00, 32'hffffffff, 32'h0);
    for (k = 0; k < 4; k++) rd({k[5:0], 2'h0} + 8'h10, 32'hffffffff, {28'h0, k[1:0], k[1:0]});
    rd(8'h40, 32'hffffffff, 32'h0);
    wr(8'h00, 32'h4);
    revision_select_pins <= 2'h2;
    chip_select_n <= 1'b0;
    supply_ok <= 1'b1;
    wait_up;
    rd(8'h04, 32'h3, 32'h2);
    run_bytes(2'h2, 6, 64);
    for (k = 0; k < 4; k++) begin
      r = k[1:0];
      external_select_enable <= k[0];
      slow <= k[1];
      revision_select_pins <= k[0] ? 2'($random(seed)) : r;
      wr(8'h00, {29'h0, 1'b1, k[0] ? r : ~r});
      reselect;
      rd(8'h04, 32'h3, {30'h0, r});
      run_bytes(r, 5, 64);
    end
    wr(8'h14, 32'h01000035);
    external_select_enable <= 1'b0;
    revision_select_pins <= 2'h1;
    reselect;
    run_bytes(2'h1, 6, 3);
    wr(8'h00, 32'h0);
    revision_select_pins <= 2'h3;
    reselect;
    rd(8'h04, 32'h3, 32'h3);
    run_bytes(2'h0, 4, 64);
    wr(8'h00, 32'h4);
    revision_select_pins <= 2'h2;
    reload_instruction <= 1'b1;
    tick(1);
    reload_instruction <= 1'b0;
    tick(3);
    // A second request while the pulse runs must not stretch or repeat it.
    reload_instruction <= 1'b1;
    tick(1);
    reload_instruction <= 1'b0;
    revision_select_pins <= 2'h3;
    rd(8'h04, 32'h3, 32'h2);
    for (i = 0; i < 80 && config_pulse_oe !== 1'b0; i++) tick(1);
    if (config_pulse_oe !== 1'b0) stall;
    tick(4);
    check(prog_cnt_r, 4'h1, "pulse count");
    rd(8'h04, 32'h3, 32'h3);
    run_bytes(2'h3, 3, 64);
    revision_select_pins <= 2'h0;
    hold_init <= 1'b1;
    tick(3);
    revision_select_pins <= 2'h1;
    tick(4);
    check(data_oe, 1'b0, "data enable");
    hold_init <= 1'b0;
    tick(4);
    rd(8'h04, 32'h3, 32'h0);
    run_bytes(2'h0, 3, 64);
    supply_low <= 1'b1;
    tick(3);
    check(output_enable_clear_n_oe, 1'b1, "line drive");
    supply_low <= 1'b0;
    wait_up;
    arst_n <= 1'b0;
    tick(2);
    arst_n <= 1'b1;
    wait_up;
    rd(8'h00, 32'hffffffff, 32'h0);
    run_bytes(2'h0, 3, 64);
    complete_run;
  end
endmodule // config_rev_control_test
bind config_rev_control cfg_rev_checker #(.RELEASE_DELAY(RELEASE_DELAY)) cfg_rev_checker_inst (.*);
